// ==== design/bag_defs.svh ====
// Purpose: Offsets, field positions, thresholds and timing counts for the battery alarm block
// Assumes: 25 MHz aclk, 32-bit AXI4-Lite register words
// Notes:   Register index i sits at byte address 4*i
`ifndef BAG_DEFS_SVH
`define BAG_DEFS_SVH

`define BAG_CLK_HZ           25000000
`define BAG_DISPLAY_REQUEST_INPUT_TIME_MS     4000
`define BAG_DEBOUNCE_MS      250
`define BAG_DISPLAY_REQUEST_INPUT_CYC         ((`BAG_DISPLAY_REQUEST_INPUT_TIME_MS * (`BAG_CLK_HZ / 1000)))
`define BAG_DEBOUNCE_CYC     ((`BAG_DEBOUNCE_MS * (`BAG_CLK_HZ / 1000)))
`define BAG_BLINK_CYC        12500000

`define BAG_UNDER_TEMP_C     16'sh0000
`define BAG_PRECHG_SPAN_C    16'sh0005
`define BAG_OT_HYST_C        16'sh0005
`define BAG_OT_FLOOR_C       16'sh002b
`define BAG_FD_CLEAR_PCT     8'h14

// Register byte offsets
`define BAG_A_CTRL           8'h00
`define BAG_A_CURRENT        8'h04
`define BAG_A_VOLTAGE        8'h08
`define BAG_A_CELL12         8'h0c
`define BAG_A_CELL34         8'h10
`define BAG_A_TEMP           8'h14
`define BAG_A_REMCAP         8'h18
`define BAG_A_FULLCAP        8'h1c
`define BAG_A_DESCAP         8'h20
`define BAG_A_TTE            8'h24
`define BAG_A_OVERCHG        8'h28
`define BAG_A_REQV           8'h2c
`define BAG_A_MARGINS        8'h30
`define BAG_A_CELLLIM        8'h34
`define BAG_A_TEMPLIM        8'h38
`define BAG_A_EDV            8'h3c
`define BAG_A_ALARMLIM       8'h40
`define BAG_A_CURRS          8'h44
`define BAG_A_MAINT          8'h48
`define BAG_A_STATUS         8'h4c
`define BAG_A_CHGREQ         8'h50
`define BAG_A_IRQ_STAT       8'h54
`define BAG_A_IRQ_MASK       8'h58

// Control register fields
`define BAG_C_UPDATE         0
`define BAG_C_DREF           1
`define BAG_C_FIVE_SEG       2
`define BAG_C_SLOPE_TERM     3
`define BAG_C_TAPER_TERM     4
`define BAG_C_DISCHARGING    5
`define BAG_C_FCCLR_LSB      8

// Status word fields
`define BAG_S_LRT            0
`define BAG_S_LCA            1
`define BAG_S_FD             4
`define BAG_S_FC             5
`define BAG_S_TDA            11
`define BAG_S_OTA            12
`define BAG_S_TCA            14
`define BAG_S_OCA            15
`define BAG_S_CELL_OVERVOLTAGE_FLAG           16
`define BAG_S_CELL_UNDERVOLTAGE_FLAG           17

`define BAG_AXI_OKAY         2'b00
`define BAG_AXI_SLVERR       2'b10

`endif

// ==== design/bag_pkg.sv ====
// Purpose: Types shared by the battery alarm block
// Assumes: Nothing beyond the defs header
// Notes:   Constants live in the defs header
package bag_pkg;
   typedef logic [15:0] bag_word_t;
   typedef enum logic [1:0] {BAG_D_IDLE, BAG_D_ON, BAG_D_WAIT_HIGH} bag_display_request_input_e;
endpackage

// ==== design/bag_debounce.sv ====
// Purpose: Three-flop synchroniser plus stability filter for a pin
// Assumes: Pin is asynchronous to aclk
// Notes:   Output changes only after the level held STABLE_CYC cycles
`timescale 1ns/1ps
module bag_debounce #(
   parameter int STABLE_CYC = 6250000,
   parameter bit INIT       = 1'b1
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   logic [2:0]    sync_r;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          lvl_r, lvl_nxt;

   // Stage 2 and 3 agree before a change counts; stage 1 feeds only stage 2
   always_comb begin
      cnt_nxt = cnt_r;
      lvl_nxt = lvl_r;
      if (sync_r[1] != sync_r[2] || sync_r[2] == lvl_r) begin
         cnt_nxt = '0;
      end else if (cnt_r == CW'(STABLE_CYC - 1)) begin
         cnt_nxt = '0;
         lvl_nxt = sync_r[2];
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   // Register the synchroniser and the filter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_r <= {3{INIT}};
         cnt_r  <= '0;
         lvl_r  <= INIT;
      end else begin
         sync_r <= {sync_r[1:0], pin_in};
         cnt_r  <= cnt_nxt;
         lvl_r  <= lvl_nxt;
      end
   end

   assign level_out = lvl_r;
endmodule

// ==== design/bag_top.sv ====
// Purpose: Battery alarm, charge request and LED gauge logic behind an AXI4-Lite slave
// Assumes: Measurements and limits written by software; update strobe marks a fresh set
// Notes:   Temperatures in signed degrees C, percentages 0..100, currents signed mA
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "bag_defs.svh"
module bag_top #(
   parameter int DISPLAY_REQUEST_INPUT_CYC     = `BAG_DISPLAY_REQUEST_INPUT_CYC,
   parameter int DEBOUNCE_CYC = `BAG_DEBOUNCE_CYC,
   parameter int BLINK_CYC    = `BAG_BLINK_CYC
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Display pin and LED drive
   input  wire logic        display_request_input_n,
   output logic [4:0]       led_on,
   // Interrupt
   output logic             irq
);
   import bag_pkg::*;

   // Software-written measurement and limit registers
   logic [31:0] ctrl_r, cur_r, volt_r, c12_r, c34_r, temp_r, rem_r, full_r, des_r, tte_r;
   logic [31:0] ovc_r, reqv_r, marg_r, clim_r, tlim_r, edv_r, alim_r, currs_r, maint_r, mask_r;
   logic [31:0] ctrl_nxt, mask_nxt;
   logic [31:0] wmask;
   logic [7:0]  wa_r, wa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic [3:0]  ws_r, ws_nxt;
   logic        awh_r, awh_nxt, wh_r, wh_nxt, bv_r, bv_nxt, wok_r, wok_nxt;
   logic        rv_r, rv_nxt, rok_nxt, rok_r;
   logic [31:0] rd_r, rd_nxt;
   logic        do_write, do_read;

   // Write side: hold address and data until both have arrived, then answer
   always_comb begin
      awh_nxt = awh_r;
      wh_nxt  = wh_r;
      wa_nxt  = wa_r;
      wd_nxt  = wd_r;
      ws_nxt  = ws_r;
      bv_nxt  = bv_r;
      wok_nxt = wok_r;
      if (s_axi_awvalid && !awh_r && !bv_r) begin
         awh_nxt = 1'b1;
         wa_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wh_r && !bv_r) begin
         wh_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
         ws_nxt = s_axi_wstrb;
      end
      if (do_write) begin
         awh_nxt = 1'b0;
         wh_nxt  = 1'b0;
         bv_nxt  = 1'b1;
         wok_nxt = (wa_r[1:0] == 2'b00) && (wa_r <= `BAG_A_IRQ_MASK);
      end else if (bv_r && s_axi_bready) begin
         bv_nxt = 1'b0;
      end
   end
   assign do_write = awh_r && wh_r && !bv_r;
   assign wmask    = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
      merge = (old & ~m) | (d & m);
   endfunction

   // Register file; update strobe self-clears so it acts as a one-cycle trigger
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {cur_r, volt_r, c12_r, c34_r, temp_r, rem_r, full_r, des_r, tte_r} <= '0;
         {ovc_r, reqv_r, marg_r, clim_r, tlim_r, edv_r, alim_r, currs_r, maint_r} <= '0;
      end else if (do_write) begin
         case (wa_r)
            `BAG_A_CURRENT:  cur_r   <= merge(cur_r, wd_r, wmask);
            `BAG_A_VOLTAGE:  volt_r  <= merge(volt_r, wd_r, wmask);
            `BAG_A_CELL12:   c12_r   <= merge(c12_r, wd_r, wmask);
            `BAG_A_CELL34:   c34_r   <= merge(c34_r, wd_r, wmask);
            `BAG_A_TEMP:     temp_r  <= merge(temp_r, wd_r, wmask);
            `BAG_A_REMCAP:   rem_r   <= merge(rem_r, wd_r, wmask);
            `BAG_A_FULLCAP:  full_r  <= merge(full_r, wd_r, wmask);
            `BAG_A_DESCAP:   des_r   <= merge(des_r, wd_r, wmask);
            `BAG_A_TTE:      tte_r   <= merge(tte_r, wd_r, wmask);
            `BAG_A_OVERCHG:  ovc_r   <= merge(ovc_r, wd_r, wmask);
            `BAG_A_REQV:     reqv_r  <= merge(reqv_r, wd_r, wmask);
            `BAG_A_MARGINS:  marg_r  <= merge(marg_r, wd_r, wmask);
            `BAG_A_CELLLIM:  clim_r  <= merge(clim_r, wd_r, wmask);
            `BAG_A_TEMPLIM:  tlim_r  <= merge(tlim_r, wd_r, wmask);
            `BAG_A_EDV:      edv_r   <= merge(edv_r, wd_r, wmask);
            `BAG_A_ALARMLIM: alim_r  <= merge(alim_r, wd_r, wmask);
            `BAG_A_CURRS:    currs_r <= merge(currs_r, wd_r, wmask);
            `BAG_A_MAINT:    maint_r <= merge(maint_r, wd_r, wmask);
            default: ;
         endcase
      end
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt[`BAG_C_UPDATE] = 1'b0;
      mask_nxt = mask_r;
      if (do_write && wa_r == `BAG_A_CTRL) ctrl_nxt = merge(ctrl_r, wd_r, wmask);
      if (do_write && wa_r == `BAG_A_IRQ_MASK) mask_nxt = merge(mask_r, wd_r, wmask);
   end

   // Field views of the packed limit registers
   logic signed [15:0] cur_s, temp_s, maxt_s;
   logic [15:0] req_i, fast_i, pre_i, maint_i;
   logic [15:0] v, cv, ov_m, oc_m, clim_ov, clim_uv, final_discharge_threshold, second_discharge_threshold;
   logic [15:0] rm, fcc, dcap, rca_v, rta_v, tte;
   logic [7:0]  fc_clr;
   logic        cell_hi, cell_lo;
   assign cur_s   = cur_r[15:0];
   assign temp_s  = temp_r[15:0];
   assign maxt_s  = tlim_r[15:0];
   assign v       = volt_r[15:0];
   assign cv      = reqv_r[15:0];
   assign ov_m    = marg_r[31:16];
   assign oc_m    = marg_r[15:0];
   assign clim_ov = clim_r[31:16];
   assign clim_uv = clim_r[15:0];
   assign final_discharge_threshold    = edv_r[15:0];
   assign second_discharge_threshold    = edv_r[31:16];
   assign rca_v   = alim_r[15:0];
   assign rta_v   = alim_r[31:16];
   assign fast_i  = currs_r[31:16];
   assign pre_i   = currs_r[15:0];
   assign maint_i = maint_r[15:0];
   assign rm      = rem_r[15:0];
   assign fcc     = full_r[15:0];
   assign dcap    = des_r[15:0];
   assign tte     = tte_r[15:0];
   assign fc_clr  = ctrl_r[`BAG_C_FCCLR_LSB +: 8];
   assign cell_hi = (c12_r[15:0] > clim_ov) || (c12_r[31:16] > clim_ov) ||
                    (c34_r[15:0] > clim_ov) || (c34_r[31:16] > clim_ov);
   assign cell_lo = (c12_r[15:0] < clim_uv) || (c12_r[31:16] < clim_uv) ||
                    (c34_r[15:0] < clim_uv) || (c34_r[31:16] < clim_uv);

   function automatic logic [7:0] pct(input logic [15:0] num, input logic [15:0] den);
      logic [23:0] q;
      q = 24'd0;
      if (den != 16'h0000) q = (24'(num) * 24'd100) / 24'(den);
      pct = (q > 24'd100) ? 8'd100 : q[7:0];
   endfunction

   // Status state and overcharge accumulator
   logic [17:0] stat_r, stat_nxt;
   logic [15:0] chg_r, chg_nxt;
   logic [31:0] added_r, added_nxt;
   logic        oc_lat_r, oc_lat_nxt, ot_lat_r, ot_lat_nxt, cell_overvoltage_flag_lat_r, cell_overvoltage_flag_lat_nxt, ovt_lat_r, ovt_lat_nxt;
   logic [7:0]  relative_charge_percent, asoc;
   logic        upd, dischg, term;
   assign upd    = ctrl_r[`BAG_C_UPDATE];
   assign dischg = ctrl_r[`BAG_C_DISCHARGING];
   assign term   = ctrl_r[`BAG_C_SLOPE_TERM] | ctrl_r[`BAG_C_TAPER_TERM];
   assign relative_charge_percent   = pct(rm, fcc);
   assign asoc   = pct(rm, dcap);

   // Condition evaluation, taken only on the update strobe
   always_comb begin
      logic [16:0] i_lim, v_lim;
      logic        oc_now, ov_now, terminate_charge_alarm;
      stat_nxt     = stat_r;
      chg_nxt      = chg_r;
      added_nxt    = added_r;
      oc_lat_nxt   = oc_lat_r;
      ot_lat_nxt   = ot_lat_r;
      cell_overvoltage_flag_lat_nxt = cell_overvoltage_flag_lat_r;
      ovt_lat_nxt  = ovt_lat_r;
      i_lim  = {1'b0, chg_r} + {1'b0, oc_m};
      v_lim  = {1'b0, cv} + {1'b0, ov_m};
      oc_now = (cur_s > 16'sh0000) && ({1'b0, cur_s[15:0]} >= i_lim);
      ov_now = {1'b0, v} >= v_lim;
      terminate_charge_alarm    = stat_r[`BAG_S_TCA];
      if (upd) begin
         // Over-temperature latch with hysteresis
         if (temp_s >= maxt_s) ot_lat_nxt = 1'b1;
         else if (temp_s <= maxt_s - `BAG_OT_HYST_C || temp_s <= `BAG_OT_FLOOR_C) ot_lat_nxt = 1'b0;
         // Cell overvoltage latch
         if (cell_hi) cell_overvoltage_flag_lat_nxt = 1'b1;
         else if (!ov_now && !cell_hi) cell_overvoltage_flag_lat_nxt = 1'b0;
         // Overcharge counter counts charge added once full
         if (dischg) added_nxt = '0;
         else if (rm >= fcc && cur_s > 16'sh0000) added_nxt = added_r + 32'(cur_s[15:0]);
         if (added_nxt >= ovc_r && ovc_r != 32'h0) oc_lat_nxt = 1'b1;
         else if (dischg) oc_lat_nxt = 1'b0;
         // Overvoltage share of terminate-charge outlives the voltage itself; only discharge ends it
         if (ov_now) ovt_lat_nxt = 1'b1;
         else if (dischg) ovt_lat_nxt = 1'b0;
         // Terminate-charge follows its causes; the termination share also drops on discharge
         terminate_charge_alarm = oc_now || ovt_lat_nxt || ot_lat_nxt || oc_lat_nxt || (term && !dischg);
         stat_nxt[`BAG_S_TCA]  = terminate_charge_alarm;
         stat_nxt[`BAG_S_OTA]  = ot_lat_nxt;
         stat_nxt[`BAG_S_OCA]  = oc_lat_nxt;
         stat_nxt[`BAG_S_CELL_OVERVOLTAGE_FLAG] = cell_overvoltage_flag_lat_nxt | ot_lat_nxt;
         // Fully charged
         if (oc_lat_nxt || term) stat_nxt[`BAG_S_FC] = 1'b1;
         else if (relative_charge_percent < fc_clr) stat_nxt[`BAG_S_FC] = 1'b0;
         // Discharge side
         if (v <= second_discharge_threshold) stat_nxt[`BAG_S_FD] = 1'b1;
         else if (relative_charge_percent > `BAG_FD_CLEAR_PCT) stat_nxt[`BAG_S_FD] = 1'b0;
         stat_nxt[`BAG_S_CELL_UNDERVOLTAGE_FLAG] = cell_lo;
         stat_nxt[`BAG_S_TDA]  = (v <= final_discharge_threshold) || cell_lo;
         stat_nxt[`BAG_S_LCA]  = rm < rca_v;
         stat_nxt[`BAG_S_LRT]  = tte < rta_v;
         // Charge request, priority zero over maintenance over pre/fast
         if (oc_now || cell_overvoltage_flag_lat_nxt || ot_lat_nxt || oc_lat_nxt || temp_s < `BAG_UNDER_TEMP_C)
            chg_nxt = 16'h0000;
         else if (term || stat_nxt[`BAG_S_FC]) chg_nxt = maint_i;
         else if (temp_s < `BAG_UNDER_TEMP_C + `BAG_PRECHG_SPAN_C) chg_nxt = pre_i;
         else chg_nxt = fast_i;
      end
   end

   // Interrupt status: sticky, set wins over clear-on-read
   logic [17:0] irq_r, irq_nxt, rise;
   logic        rd_irq;
   assign rise   = stat_nxt & ~stat_r;
   assign rd_irq = do_read && s_axi_araddr == `BAG_A_IRQ_STAT;
   always_comb begin
      irq_nxt = rd_irq ? rise : (irq_r | rise);
   end

   // All condition outputs update in the same edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r     <= '0;
         mask_r     <= '0;
         stat_r     <= '0;
         chg_r      <= '0;
         added_r    <= '0;
         oc_lat_r   <= 1'b0;
         ot_lat_r   <= 1'b0;
         cell_overvoltage_flag_lat_r <= 1'b0;
         ovt_lat_r  <= 1'b0;
         irq_r      <= '0;
         irq        <= 1'b0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         mask_r     <= mask_nxt;
         stat_r     <= stat_nxt;
         chg_r      <= chg_nxt;
         added_r    <= added_nxt;
         oc_lat_r   <= oc_lat_nxt;
         ot_lat_r   <= ot_lat_nxt;
         cell_overvoltage_flag_lat_r <= cell_overvoltage_flag_lat_nxt;
         ovt_lat_r  <= ovt_lat_nxt;
         irq_r      <= irq_nxt;
         irq        <= |(irq_nxt & mask_nxt[17:0]);
      end
   end

   // Read side: one read at a time, answered the cycle after arvalid
   assign do_read = s_axi_arvalid && !rv_r;
   always_comb begin
      rv_nxt  = rv_r;
      rd_nxt  = rd_r;
      rok_nxt = rok_r;
      if (do_read) begin
         rv_nxt  = 1'b1;
         rok_nxt = 1'b1;
         case (s_axi_araddr)
            `BAG_A_CTRL:     rd_nxt = ctrl_r;
            `BAG_A_CURRENT:  rd_nxt = cur_r;
            `BAG_A_VOLTAGE:  rd_nxt = volt_r;
            `BAG_A_TEMP:     rd_nxt = temp_r;
            `BAG_A_REMCAP:   rd_nxt = rem_r;
            `BAG_A_STATUS:   rd_nxt = {14'h0, stat_r};
            `BAG_A_CHGREQ:   rd_nxt = {16'h0, chg_r};
            `BAG_A_IRQ_STAT: rd_nxt = {14'h0, irq_r};
            `BAG_A_IRQ_MASK: rd_nxt = mask_r;
            default: begin
               rd_nxt  = 32'h0;
               rok_nxt = 1'b0;
            end
         endcase
      end else if (rv_r && s_axi_rready) begin
         rv_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awh_r <= 1'b0;
         wh_r  <= 1'b0;
         wa_r  <= '0;
         wd_r  <= '0;
         ws_r  <= '0;
         bv_r  <= 1'b0;
         wok_r <= 1'b0;
         rv_r  <= 1'b0;
         rd_r  <= '0;
         rok_r <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_arready <= 1'b1;
         s_axi_bresp   <= `BAG_AXI_OKAY;
         s_axi_rresp   <= `BAG_AXI_OKAY;
      end else begin
         awh_r <= awh_nxt;
         wh_r  <= wh_nxt;
         wa_r  <= wa_nxt;
         wd_r  <= wd_nxt;
         ws_r  <= ws_nxt;
         bv_r  <= bv_nxt;
         wok_r <= wok_nxt;
         rv_r  <= rv_nxt;
         rd_r  <= rd_nxt;
         rok_r <= rok_nxt;
         // Readies taken from next state so they track the holding flops with no extra cycle
         s_axi_awready <= !awh_nxt && !bv_nxt;
         s_axi_wready  <= !wh_nxt && !bv_nxt;
         s_axi_arready <= !rv_nxt;
         s_axi_bresp   <= wok_nxt ? `BAG_AXI_OKAY : `BAG_AXI_SLVERR;
         s_axi_rresp   <= rok_nxt ? `BAG_AXI_OKAY : `BAG_AXI_SLVERR;
      end
   end
   assign s_axi_bvalid  = bv_r;
   assign s_axi_rvalid  = rv_r;
   assign s_axi_rdata   = rd_r;

   // Display request pin, filtered
   logic display_request_input_lvl;
   bag_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .INIT(1'b1)) u_display_request_input_db (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .pin_in    (display_request_input_n),
      .level_out (display_request_input_lvl)
   );

   // Display timer: fall starts it, pin must return high before another
   bag_display_request_input_e   dst_r, dst_nxt;
   logic        dlvl_r;
   logic [31:0] dcnt_r, dcnt_nxt, bcnt_r, bcnt_nxt;
   logic        blink_r, blink_nxt;
   logic [4:0]  led_nxt;
   always_comb begin
      logic [7:0] soc;
      logic [4:0] bar;
      soc       = 8'h00;
      bar       = 5'h00;
      dst_nxt   = dst_r;
      dcnt_nxt  = dcnt_r;
      bcnt_nxt  = (bcnt_r == 32'(BLINK_CYC - 1)) ? 32'h0 : bcnt_r + 32'h1;
      blink_nxt = (bcnt_r == 32'(BLINK_CYC - 1)) ? ~blink_r : blink_r;
      case (dst_r)
         BAG_D_IDLE: if (dlvl_r && !display_request_input_lvl) begin
            dst_nxt  = BAG_D_ON;
            dcnt_nxt = '0;
         end
         BAG_D_ON: if (dcnt_r == 32'(DISPLAY_REQUEST_INPUT_CYC - 1)) dst_nxt = BAG_D_WAIT_HIGH;
                   else dcnt_nxt = dcnt_r + 32'h1;
         BAG_D_WAIT_HIGH: if (display_request_input_lvl) dst_nxt = BAG_D_IDLE;
         default: dst_nxt = BAG_D_IDLE;
      endcase
      soc = ctrl_r[`BAG_C_DREF] ? asoc : relative_charge_percent;
      if (ctrl_r[`BAG_C_FIVE_SEG])
         bar = {soc >= 8'd80, soc >= 8'd60, soc >= 8'd40, soc >= 8'd20, 1'b1};
      else
         bar = {1'b0, soc >= 8'd75, soc >= 8'd50, soc >= 8'd25, 1'b1};
      if (dst_r != BAG_D_ON || stat_r[`BAG_S_TDA] && v <= final_discharge_threshold) bar = 5'h00;
      if (stat_r[`BAG_S_LCA] && blink_r) bar = 5'h00;
      led_nxt = bar;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dst_r   <= BAG_D_IDLE;
         dlvl_r  <= 1'b1;
         dcnt_r  <= '0;
         bcnt_r  <= '0;
         blink_r <= 1'b0;
         led_on  <= 5'h00;
      end else begin
         dst_r   <= dst_nxt;
         dlvl_r  <= display_request_input_lvl;
         dcnt_r  <= dcnt_nxt;
         bcnt_r  <= bcnt_nxt;
         blink_r <= blink_nxt;
         led_on  <= led_nxt;
      end
   end
endmodule

// ==== verif/bag_button.sv ====
// Purpose: Push-button model on the display request pin
// Assumes: Pin has a pull-up, so it reads high while released
// Notes:   Press length is counted in aclk cycles
`timescale 1ns/1ps
module bag_button (
   // Clock and pin
   input  wire logic aclk,
   output logic      pin_n
);
   initial pin_n = 1'b1;
   // Hold low, then let the pull-up bring the level back
   task automatic press(input int cyc);
      pin_n <= 1'b0;
      repeat (cyc) @(posedge aclk);
      pin_n <= 1'b1;
   endtask
endmodule

// ==== verif/bag_monitor.sv ====
// Purpose: Port-level checks for the battery alarm block
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Counts follow the parameters of the bound instance
`timescale 1ns/1ps
module bag_monitor #(
   parameter int DISPLAY_REQUEST_INPUT_CYC     = 200,
   parameter int DEBOUNCE_CYC = 10
) (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   // Display and interrupt
   input wire logic       display_request_input_n,
   input wire logic [4:0] led_on,
   input wire logic       irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   int   hi_cnt_r;
   int   hi_cnt_nxt;
   logic quiet;
   // Pin-high run length, saturating so it cannot wrap in a long idle stretch
   always_comb hi_cnt_nxt = !display_request_input_n ? 0 : (hi_cnt_r < 1000000 ? hi_cnt_r + 1 : hi_cnt_r);
   always_ff @(posedge aclk) hi_cnt_r <= aresetn ? hi_cnt_nxt : 0;
   assign quiet = hi_cnt_r > DISPLAY_REQUEST_INPUT_CYC + DEBOUNCE_CYC + 8;
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_led_dark: assert property (quiet |-> led_on == 5'h00) else $error("display lit long after release");
   chk_glitch_ignored: assert property (quiet && !display_request_input_n |-> (led_on == 5'h00) [*8])
      else $error("display lit before the pin settled");
   chk_led_bar: assert property (led_on inside {5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f})
      else $error("segments not a bar");
   chk_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
   chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("read answer late");
   chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
   chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && led_on == 5'h00) else $error("outputs busy after reset");
endmodule
bind bag_top bag_monitor #(.DISPLAY_REQUEST_INPUT_CYC(DISPLAY_REQUEST_INPUT_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) mon_u (.*);

// ==== verif/battery_alarm_status_and_led_gauge_bench.sv ====
// Purpose: Self-checking bench for the battery alarm block
// Assumes: Short display, debounce and blink counts via parameters
// Notes:   Bus answers are checked against a queue of notes
`timescale 1ns/1ps
`include "bag_defs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module battery_alarm_status_and_led_gauge_bench;
   logic        aclk = 1'b0, aresetn = 1'b0, display_request_input_n;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [4:0]  led_on;
   logic [34:0] q[$], e;
   int          n_fail = 0, num_checks = 0, seed = 4, i;
   // Healthy set for registers 0x04..0x48, then single-input cases
   logic [31:0] base [18] = '{32'h10, 32'h3000, 32'h0f000f00, 32'h0f000f00, 32'h19, 32'h800, 32'h1000, 32'h2000,
      32'h64, 32'hffff, 32'h4000, 32'h01000100, 32'h10000a00, 32'h2d, 32'h20001000, 32'h000a0100, 32'h03e800c8, 32'h32};
   logic [7:0]  ca [13] = '{8'h00, 8'h00, 8'h14, 8'h14, 8'h14, 8'h0c, 8'h10, 8'h18, 8'h24, 8'h04, 8'h08, 8'h08, 8'h08};
   logic [31:0] cv [13] = '{32'h15, 32'hd, 32'hffff, 32'h2, 32'h2d, 32'h11000f00, 32'h0f000900, 32'h80, 32'h5,
      32'h500, 32'h4100, 32'h1800, 32'h0f00};
   logic [17:0] cs [13] = '{18'h4020, 18'h4020, 18'h0, 18'h0, 18'h15000, 18'h10000, 18'h20800, 18'h2, 18'h1, 18'h4000,
      18'h4000, 18'h10, 18'h810};
   logic [15:0] cc [13] = '{16'h32, 16'h32, 16'h0, 16'hc8, 16'h0, 16'h0, 16'h3e8, 16'h3e8, 16'h3e8, 16'h0, 16'h3e8,
      16'h3e8, 16'h3e8};
   logic [31:0] lc [3] = '{32'h5, 32'h1, 32'h7};
   logic [4:0]  le [3] = '{5'h1f, 5'h0f, 5'h07};
   always #20 aclk = ~aclk;
   bag_button btn_u (.aclk(aclk), .pin_n(display_request_input_n));
   bag_top #(.DISPLAY_REQUEST_INPUT_CYC(200), .DEBOUNCE_CYC(10), .BLINK_CYC(8)) dut_u (.*);
   task automatic complete_run(input bit hung);
      if (hung) n_fail++;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Both halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n = 0;
      q.push_back({1'b1, r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (n < 50 && (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid));
      if (n >= 50) complete_run(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [34:0] x);
      int n = 0;
      q.push_back(x);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (n < 50 && (s_axi_arvalid || !s_axi_rvalid));
      if (n >= 50) complete_run(1);
   endtask
   // Oldest note against each completed answer; bit 34 skips the data
   always @(posedge aclk) begin
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
         e = q.pop_front();
         `CHK(s_axi_bvalid ? s_axi_bresp : s_axi_rresp, e[33:32])
         if (!e[34]) `CHK(s_axi_rdata, e[31:0])
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 18; i++) wr(8'h04 + 8'(4 * i), base[i], 2'b00);
      wr(`BAG_A_IRQ_MASK, 32'h2, 2'b00);
      // Perturb one input, evaluate, read back, then restore while discharging
      for (i = 0; i < 13; i++) begin
         wr(ca[i], cv[i], 2'b00);
         wr(`BAG_A_CTRL, ca[i] == 8'h00 ? cv[i] : 32'h5, 2'b00);
         rd(`BAG_A_STATUS, {17'h0, cs[i]});
         rd(`BAG_A_CHGREQ, {19'h0, cc[i]});
         if (ca[i] != 8'h00) wr(ca[i], base[ca[i] / 4 - 1], 2'b00);
         wr(`BAG_A_CTRL, 32'h3c25, 2'b00);
      end
      `CHK(irq, 1'b1)
      wr(`BAG_A_IRQ_MASK, 32'h0, 2'b00);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      rd(`BAG_A_IRQ_STAT, {1'b0, 2'b00, 32'h00035833});
      wr(`BAG_A_IRQ_MASK, 32'h2, 2'b00);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      rd(8'h5c, {1'b0, 2'b10, 32'h0});
      wr(8'h06, 32'h1, 2'b10);
      wr(`BAG_A_REMCAP, 32'hd00, 2'b00);
      btn_u.press(2 + ($random(seed) & 3));
      repeat (30) @(posedge aclk);
      `CHK(led_on, 5'h00)
      for (i = 0; i < 3; i++) begin
         wr(`BAG_A_CTRL, lc[i], 2'b00);
         btn_u.press(40);
         `CHK(led_on, le[i])
         repeat (250) @(posedge aclk);
         `CHK(led_on, 5'h00)
      end
      complete_run(0);
   end
   // Cut a hang short
   initial begin
      repeat (100000) @(posedge aclk);
      complete_run(1);
   end
endmodule
